// ### pdcr_pkg.sv
// Package of offsets, field layouts and reset values for the divider configuration bank
package pdcr_pkg;
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 8;
   // ************************************************************
   // Byte offsets
   // ************************************************************
   localparam logic [7:0]  OFF_PROG_ENABLE = 8'h0A;
   localparam logic [7:0]  OFF_GEAR_REF    = 8'h0B;
   localparam logic [7:0]  OFF_GEAR_FB     = 8'h0C;
   localparam logic [7:0]  OFF_GEAR_OUT    = 8'h0D;
   localparam logic [7:0]  OFF_RSVD_A      = 8'h0E;
   localparam logic [7:0]  OFF_RSVD_B      = 8'h0F;
   localparam logic [7:0]  OFF_RSVD_C      = 8'h10;
   localparam logic [7:0]  OFF_UNITY_REF   = 8'h11;
   localparam logic [7:0]  OFF_UNITY_FB    = 8'h12;
   localparam logic [7:0]  OFF_UNITY_OUT   = 8'h13;
   localparam logic [7:0]  OFF_RSVD_D      = 8'h14;
   localparam logic [7:0]  OFF_FACTORY     = 8'h15;
   // ************************************************************
   // Field layouts
   // ************************************************************
   localparam int          PROG_EN_BIT     = 7;
   localparam int          M_W             = 6;
   localparam int          N_W             = 8;
   localparam int          POST_W          = 4;
   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0]  RST_ZERO        = 8'h00;
   localparam logic [5:0]  RST_M           = 6'h00;
   localparam logic [7:0]  RST_N           = 8'h00;
   localparam logic [3:0]  RST_POST        = 4'h0;
endpackage : pdcr_pkg

// ### pdcr_field.sv
// Read-write field register with a staged copy and an applied copy
`timescale 1ns/10ps
`default_nettype none
module pdcr_field #(
   parameter int          W   = 8,
   parameter logic [7:0]  RST = 8'h00
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          wr_en,
   input  wire logic [W-1:0]  wr_data,
   input  wire logic          apply,
   output logic      [W-1:0]  staged,
   output logic      [W-1:0]  applied
);
   // Reset value is carried in one byte, so wider fields cannot be served
   if (W < 1 || W > 8) begin : g_bad_width
      $error("pdcr_field width must be 1..8");
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         staged <= RST[W-1:0];
      end else if (wr_en) begin
         staged <= wr_data;
      end
   end

   // Applied copy follows the staged copy only while apply is high
   always_ff @(posedge clk) begin
      if (rst) begin
         applied <= RST[W-1:0];
      end else if (apply) begin
         applied <= staged;
      end
   end
endmodule // pdcr_field
`default_nettype wire

// ### pdcr_rsvd.sv
// Read decode of the reserved and fixed-zero byte offsets
`timescale 1ns/10ps
`default_nettype none
module pdcr_rsvd (
   input  wire logic [7:0]  addr,
   output logic             is_rsvd
);
   always_comb begin
      unique case (addr)
         pdcr_pkg::OFF_RSVD_A,
         pdcr_pkg::OFF_RSVD_B,
         pdcr_pkg::OFF_RSVD_C,
         pdcr_pkg::OFF_RSVD_D: is_rsvd = 1'b1;
         default:              is_rsvd = 1'b0;
      endcase
   end
endmodule // pdcr_rsvd
`default_nettype wire

// ### pdcr_regs.sv
// Divider configuration byte bank: M, N and post divider registers for both PLLs
`timescale 1ns/10ps
`default_nettype none
module pdcr_regs (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        wr_en,
   input  wire logic [7:0]  addr,
   input  wire logic [7:0]  wr_data,
   output logic      [7:0]  rd_data,
   output logic             prog_enable,
   output logic      [5:0]  gear_m_div,
   output logic      [7:0]  gear_n_div,
   output logic      [3:0]  gear_post_divider_bit,
   output logic      [5:0]  unity_m_div,
   output logic      [7:0]  unity_n_div,
   output logic      [3:0]  unity_post_divider_bit,
   output logic      [7:0]  factory_test
);
   // ************************************************************
   // Write decode
   // ************************************************************
   logic            we_gm, we_gn, we_go, we_um, we_un, we_uo;
   logic [5:0]      gm_s, um_s;
   logic [7:0]      gn_s, un_s;
   logic [3:0]      go_s, uo_s;
   logic            is_rsvd;

   assign we_gm = wr_en && (addr == pdcr_pkg::OFF_GEAR_REF);
   assign we_gn = wr_en && (addr == pdcr_pkg::OFF_GEAR_FB);
   assign we_go = wr_en && (addr == pdcr_pkg::OFF_GEAR_OUT);
   assign we_um = wr_en && (addr == pdcr_pkg::OFF_UNITY_REF);
   assign we_un = wr_en && (addr == pdcr_pkg::OFF_UNITY_FB);
   assign we_uo = wr_en && (addr == pdcr_pkg::OFF_UNITY_OUT);

   always_ff @(posedge clk) begin
      if (rst) begin
         prog_enable <= 1'b0;
      end else if (wr_en && addr == pdcr_pkg::OFF_PROG_ENABLE) begin
         prog_enable <= wr_data[pdcr_pkg::PROG_EN_BIT];
      end
   end

   // factory byte held, never acted on
   always_ff @(posedge clk) begin
      if (rst) begin
         factory_test <= pdcr_pkg::RST_ZERO;
      end else if (wr_en && addr == pdcr_pkg::OFF_FACTORY) begin
         factory_test <= wr_data;
      end
   end

   // ************************************************************
   // Divider fields
   // ************************************************************
   // gear M in byte 11
   pdcr_field #(.W(pdcr_pkg::M_W), .RST(pdcr_pkg::RST_ZERO)) u_gm (
      .clk(clk), .rst(rst), .wr_en(we_gm), .wr_data(wr_data[5:0]),
      .apply(prog_enable), .staged(gm_s), .applied(gear_m_div));
   pdcr_field #(.W(pdcr_pkg::N_W), .RST(pdcr_pkg::RST_ZERO)) u_gn (
      .clk(clk), .rst(rst), .wr_en(we_gn), .wr_data(wr_data),
      .apply(prog_enable), .staged(gn_s), .applied(gear_n_div));
   // gear post divider; not gated by the M/N enable
   pdcr_field #(.W(pdcr_pkg::POST_W), .RST(pdcr_pkg::RST_ZERO)) u_go (
      .clk(clk), .rst(rst), .wr_en(we_go), .wr_data(wr_data[3:0]),
      .apply(1'b1), .staged(go_s), .applied(gear_post_divider_bit));
   pdcr_field #(.W(pdcr_pkg::M_W), .RST(pdcr_pkg::RST_ZERO)) u_um (
      .clk(clk), .rst(rst), .wr_en(we_um), .wr_data(wr_data[5:0]),
      .apply(prog_enable), .staged(um_s), .applied(unity_m_div));
   pdcr_field #(.W(pdcr_pkg::N_W), .RST(pdcr_pkg::RST_ZERO)) u_un (
      .clk(clk), .rst(rst), .wr_en(we_un), .wr_data(wr_data),
      .apply(prog_enable), .staged(un_s), .applied(unity_n_div));
   pdcr_field #(.W(pdcr_pkg::POST_W), .RST(pdcr_pkg::RST_ZERO)) u_uo (
      .clk(clk), .rst(rst), .wr_en(we_uo), .wr_data(wr_data[3:0]),
      .apply(1'b1), .staged(uo_s), .applied(unity_post_divider_bit));

   pdcr_rsvd u_rsvd (.addr(addr), .is_rsvd(is_rsvd));

   // ************************************************************
   // Read path, registered so the output comes from a flip-flop
   // ************************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data <= pdcr_pkg::RST_ZERO;
      end else if (is_rsvd) begin
         rd_data <= pdcr_pkg::RST_ZERO;
      end else begin
         unique case (addr)
            pdcr_pkg::OFF_PROG_ENABLE: rd_data <= {prog_enable, 7'h00};
            pdcr_pkg::OFF_GEAR_REF:    rd_data <= {2'h0, gm_s};
            pdcr_pkg::OFF_GEAR_FB:     rd_data <= gn_s;
            pdcr_pkg::OFF_GEAR_OUT:    rd_data <= {4'h0, go_s};
            pdcr_pkg::OFF_UNITY_REF:   rd_data <= {2'h0, um_s};
            pdcr_pkg::OFF_UNITY_FB:    rd_data <= un_s;
            pdcr_pkg::OFF_UNITY_OUT:   rd_data <= {4'h0, uo_s};
            pdcr_pkg::OFF_FACTORY:     rd_data <= factory_test;
            default:                   rd_data <= pdcr_pkg::RST_ZERO;
         endcase
      end
   end
endmodule // pdcr_regs
`default_nettype wire

// ### pdcr_properties.sv
// Concurrent checks on the divider configuration bank ports
`timescale 1ns/10ps
`default_nettype none
module pdcr_properties (
   input wire logic       clk, rst, wr_en, prog_enable,
   input wire logic [7:0] addr, wr_data, rd_data, gear_n_div, unity_n_div, factory_test,
   input wire logic [5:0] gear_m_div, unity_m_div,
   input wire logic [3:0] gear_post_divider_bit, unity_post_divider_bit
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Write, then hold the address for one read cycle
   property rb(a, m);
      wr_en && addr == a ##1 !wr_en && addr == a |=> rd_data == ($past(wr_data, 2) & m);
   endproperty
   gear_n_rb_a: assert property (rb(8'h0C, 8'hFF)) else $error("gear N readback");
   gear_post_rb_a: assert property (rb(8'h0D, 8'h0F)) else $error("gear post readback");
   unity_m_rb_a: assert property (rb(8'h11, 8'h3F)) else $error("unity M readback");
   unity_n_rb_a: assert property (rb(8'h12, 8'hFF)) else $error("unity N readback");
   unity_post_rb_a: assert property (rb(8'h13, 8'h0F)) else $error("unity post readback");
   gear_m_apply_a: assert property (wr_en && addr == 8'h0B && prog_enable |=> ##1
      {2'h0, gear_m_div} == ($past(wr_data, 2) & 8'h3F)) else $error("gear M not applied");
   // Two disabled cycles rule out any latency reading of the enable
   frozen_div_a: assert property (!prog_enable ##1 !prog_enable |=>
      $stable(gear_n_div) && $stable(unity_m_div)) else $error("divider moved while off");
   rsvd_zero_a: assert property (addr inside {8'h0E, 8'h0F, 8'h10, 8'h14} |=>
      rd_data == 8'h00) else $error("reserved byte not zero");
   cover property (wr_en && prog_enable && addr == 8'h12);
   cover property (wr_en && addr == 8'h14);
   cover property ($rose(prog_enable));
endmodule // pdcr_properties
bind pdcr_regs pdcr_properties u_props (.*);
`default_nettype wire

// ### pdcr_host.sv
// Host-side model issuing single byte reads, and single byte writes to every offset but the factory byte 8'h15
`timescale 1ns/10ps
`default_nettype none
module pdcr_host (
   input  wire logic       clk,
   input  wire logic [7:0] rd_data,
   output var  logic       wr_en,
   output var  logic [7:0] addr, wr_data
);
   initial {wr_en, addr, wr_data} = '0;
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk);
      if (a != 8'h15) begin
         #1 {wr_en, addr, wr_data} = {1'b1, a, d};
         @(posedge clk);
         #1 wr_en = 1'b0;
         wr_data = ~d;
      end
   endtask
   // Address held two edges so either read latency reading is met
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      #1 addr = a;
      repeat (2) @(posedge clk);
      #1 d = rd_data;
   endtask
endmodule // pdcr_host
`default_nettype wire

// ### pdcr_regs_tb_top.sv
// Self-checking testbench for the divider configuration bank
`timescale 1ns/10ps
`default_nettype none
module pdcr_regs_tb_top;
   logic       clk = 1'b0, rst = 1'b1, wr_en, prog_enable;
   logic [7:0] addr, wr_data, rd_data, gear_n_div, unity_n_div, factory_test, d;
   logic [5:0] gear_m_div, unity_m_div;
   logic [3:0] gear_post_divider_bit, unity_post_divider_bit;
   int         failures = 0, checks_done = 0, cyc = 0;
   always #20 clk = ~clk;
   pdcr_host HOST (.clk(clk), .rd_data(rd_data), .wr_en(wr_en), .addr(addr), .wr_data(wr_data));
   pdcr_regs DUT (.*);
   task automatic chk(input string n, input logic [7:0] e, g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         failures++;
         finish_test;
      end
   end
   task automatic t_reset;
      for (int a = 8'h0A; a <= 8'h15; a++) begin
         HOST.rd(8'(a), d);
         chk("reset byte", 8'h00, d);
      end
      chk("test byte", 8'h00, factory_test);
   endtask
   task automatic t_frozen;
      HOST.wr(8'h0C, 8'hA5);
      HOST.rd(8'h0C, d);
      chk("gear n staged", 8'hA5, d);
      chk("gear n applied", 8'h00, gear_n_div);
   endtask
   // All-ones writes expose every reserved bit and field mask of the divider and reserved bytes
   task automatic t_fields;
      logic [7:0] off[10] = '{8'h0B, 8'h0C, 8'h0D, 8'h11, 8'h12, 8'h13,
                              8'h0E, 8'h0F, 8'h10, 8'h14};
      logic [7:0] msk[10] = '{8'h3F, 8'hFF, 8'h0F, 8'h3F, 8'hFF, 8'h0F,
                              8'h00, 8'h00, 8'h00, 8'h00};
      HOST.wr(8'h0A, 8'h80);
      chk("enable", 8'h01, {7'h0, prog_enable});
      foreach (off[i]) begin
         HOST.wr(off[i], 8'hFF);
         HOST.rd(off[i], d);
         chk("byte", msk[i], d);
      end
      chk("gear m", 8'h3F, {2'h0, gear_m_div});
      chk("gear n", 8'hFF, gear_n_div);
      chk("gear post", 8'h0F, {4'h0, gear_post_divider_bit});
      chk("unity m", 8'h3F, {2'h0, unity_m_div});
      chk("unity n", 8'hFF, unity_n_div);
      chk("unity post", 8'h0F, {4'h0, unity_post_divider_bit});
   endtask
   initial begin
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      t_reset;
      t_frozen;
      t_fields;
      finish_test;
   end
endmodule // pdcr_regs_tb_top
`default_nettype wire
